// >>> verilog/srg_top.sv
/*
 * srg_top: rate generator and status register of a sync serial port, AHB-Lite slave.
 * assumes: single master, word transfers; bus peer drives sda/scl pins
 * and their edges, sampled on ref_clk_in.
 */
// Operation
// - the rate counter clocks the port in master modes from the reload register.
// - a write to the shift buffer starts the rate counter when the port is enabled as master.
// - at the end of a transfer the counter stops and the clock pin holds its level.
// - the reload register is copied into the counter twice per serial clock period.
// - one serial clock period is two counter rollovers.
// - unimplemented locations and bits read as zero.
// - the sample phase bit chooses end or middle sampling in the SPI modes; software keeps it clear as slave.
// - the clock edge bit chooses the transmit edge in the SPI modes.
// - in two-wire mode the clock edge bit selects bus-management input thresholds.
// - the data/address bit shows whether the last byte was data or address.
// - the stop bit shows a stop was the last condition and clears when disabled.
// - the start bit shows a start was the last condition and clears when disabled.
// - in ten bit slave addressing the address refresh bit never sets, since only a master transfer ends a byte.
// - the buffer full flag tracks a full receive buffer or a byte shifting out.
`timescale 1ns/1ps
module srg_top #(
	parameter int DATA_BITS = 8
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sda_in,
	input wire logic scl_in,
	input wire logic sdi_in,
	input wire logic ten_bit_addr_in,
	output logic scl_out,
	output logic scl_oe_out,
	output logic sda_out,
	output logic sda_oe_out,
	output logic smbus_levels_out,
	output logic irq_out
);
	import srg_pkg::*;

	// bus address phase capture
	logic wr_q, wr_d, rd_q, rd_d;
	logic [7:0] adr_q, adr_d;
	logic [7:0] reload_q, reload_d, shift_q, shift_d, stat_q, stat_d;
	logic [2:0] ctrl_q, ctrl_d;
	logic [EV_WIDTH-1:0] ev_q, ev_d, mask_q, mask_d, ev_set;
	logic [4:0] half_q, half_d;
	logic sclo_q, sclo_d, sdao_q, sdao_d, mid_q, mid_d, addr_next_q, addr_next_d;
	srg_state_t st_q, st_d;
	logic [2:0] pins, pins_q;
	logic roll, load, buf_wr;
	logic [7:0] cnt;
	logic [31:0] rdata;
	logic sda_s, scl_s, sdi_s, sda_p, scl_p;
	logic start_ev, stop_ev, byte_done;

	srg_sync #(.WIDTH(3)) u_sync (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.pin_in({sdi_in, scl_in, sda_in}),
		.level_out(pins)
	);
	assign sda_s = pins[0];
	assign scl_s = pins[1];
	assign sdi_s = pins[2];
	assign sda_p = pins_q[0];
	assign scl_p = pins_q[1];

	// start is sda falling with scl high, stop is sda rising with scl high
	assign start_ev = ctrl_q[CT_TWO_WIRE] && scl_s && scl_p && sda_p && !sda_s;
	assign stop_ev = ctrl_q[CT_TWO_WIRE] && scl_s && scl_p && !sda_p && sda_s;

	// bus decode; zero wait states, response always OKAY
	always_comb begin
		wr_d = 1'b0;
		rd_d = 1'b0;
		adr_d = adr_q;
		if (hsel && hready && htrans[1]) begin
			wr_d = hwrite;
			rd_d = !hwrite;
			adr_d = haddr[7:0];
		end
	end
	assign buf_wr = wr_q && adr_q == OFF_BUFFER;

	srg_counter #(.WIDTH(8)) u_cnt (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.run_in(st_q == SRG_RUN),
		.load_in(load),
		.reload_in(reload_q),
		.roll_out(roll),
		.count_out(cnt)
	);
	// buffer write reloads the counter so the first half period is full length
	assign load = buf_wr && ctrl_q[CT_ENABLE] && ctrl_q[CT_MASTER];

	// transfer sequencer: each rollover toggles the clock, two per period
	always_comb begin
		st_d = st_q;
		half_d = half_q;
		sclo_d = sclo_q;
		sdao_d = sdao_q;
		mid_d = mid_q;
		shift_d = shift_q;
		byte_done = 1'b0;
		case (st_q)
			SRG_IDLE: begin
				if (load) begin
					st_d = SRG_RUN;
					half_d = '0;
					sdao_d = hwdata[7]; // the old buffer is not yet replaced here
				end
			end
			SRG_RUN: begin
				if (!ctrl_q[CT_ENABLE]) begin
					st_d = SRG_IDLE;
				end else if (roll) begin
					sclo_d = !sclo_q;
					half_d = half_q + 5'h01;
					// edge bit picks which clock edge launches data
					if (sclo_q == ctrl_q[CT_TWO_WIRE] ? 1'b0 : stat_q[ST_EDGE]) begin
						sdao_d = shift_q[6];
					end
					// mid-bit sample is held until the shift at the end of the bit
					mid_d = half_q[0] ? mid_q : sdi_s;
					if (half_q[0]) begin
						shift_d = {shift_q[6:0], stat_q[ST_SAMPLE] || ctrl_q[CT_TWO_WIRE] ? sdi_s : mid_q};
						sdao_d = shift_q[6];
					end
					if (half_q + 5'h01 == HALF_PERIODS) begin
						st_d = SRG_IDLE;
						byte_done = 1'b1;
						// release data after the last bit so the acknowledge slot is free
						sdao_d = 1'b1;
					end
				end
			end
			default: st_d = SRG_IDLE;
		endcase
		if (buf_wr) begin
			shift_d = hwdata[7:0];
		end
	end

	// status: software owns bits 7..6, hardware owns the rest
	always_comb begin
		stat_d = stat_q;
		addr_next_d = addr_next_q;
		if (wr_q && adr_q == OFF_STATUS) begin
			stat_d[ST_SAMPLE] = hwdata[ST_SAMPLE];
			stat_d[ST_EDGE] = hwdata[ST_EDGE];
		end
		if (start_ev) begin
			stat_d[ST_START] = 1'b1;
			stat_d[ST_STOP] = 1'b0;
			stat_d[ST_DATA] = 1'b0;
			addr_next_d = 1'b1;
		end
		if (stop_ev) begin
			stat_d[ST_STOP] = 1'b1;
			stat_d[ST_START] = 1'b0;
		end
		// the first byte after a start is the address, every later one is data
		if (byte_done && ctrl_q[CT_TWO_WIRE]) begin
			stat_d[ST_DATA] = !addr_next_q;
			addr_next_d = 1'b0;
			if (addr_next_q) begin
				stat_d[ST_RW] = shift_d[0];
				stat_d[ST_ADDR_REFRESH] = ten_bit_addr_in && !ctrl_q[CT_MASTER];
			end
		end
		// full on buffer write and again at byte end unless two-wire with ST_RW set; a buffer read empties it
		if (buf_wr) begin
			stat_d[ST_FULL] = 1'b1;
		end else if (byte_done) begin
			stat_d[ST_FULL] = !ctrl_q[CT_TWO_WIRE] || !stat_q[ST_RW];
		end else if (rd_q && adr_q == OFF_BUFFER) begin
			stat_d[ST_FULL] = 1'b0;
		end
		if (wr_q && adr_q == OFF_RELOAD) begin
			stat_d[ST_ADDR_REFRESH] = 1'b0;
		end
		if (!ctrl_q[CT_ENABLE]) begin
			stat_d[ST_STOP] = 1'b0;
			stat_d[ST_START] = 1'b0;
		end
	end

	// registers, interrupts
	always_comb begin
		reload_d = reload_q;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		ev_set = '0;
		ev_set[EV_DONE] = byte_done;
		ev_set[EV_START] = start_ev;
		ev_set[EV_STOP] = stop_ev;
		ev_set[EV_FULL] = stat_d[ST_FULL] && !stat_q[ST_FULL];
		ev_set[EV_REFRESH] = stat_d[ST_ADDR_REFRESH] && !stat_q[ST_ADDR_REFRESH];
		ev_d = ev_q;
		if (wr_q) begin
			case (adr_q)
				OFF_RELOAD: reload_d = hwdata[7:0];
				OFF_CTRL: ctrl_d = hwdata[2:0];
				OFF_IRQ_MASK: mask_d = hwdata[EV_WIDTH-1:0];
				OFF_IRQ_STAT: ev_d = ev_q & ~hwdata[EV_WIDTH-1:0];
				default: ;
			endcase
		end
		ev_d = ev_d | ev_set; // set wins over clear
	end

	// read mux, unmapped and unused bits return zero
	always_comb begin
		rdata = 32'h0000_0000;
		case (adr_q)
			OFF_RELOAD: rdata[7:0] = reload_q;
			OFF_BUFFER: rdata[7:0] = shift_q;
			OFF_STATUS: rdata[7:0] = stat_q;
			OFF_CTRL: rdata[2:0] = ctrl_q;
			OFF_IRQ_STAT: rdata[EV_WIDTH-1:0] = ev_q;
			OFF_IRQ_MASK: rdata[EV_WIDTH-1:0] = mask_q;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			adr_q <= 8'h00;
			reload_q <= RST_RELOAD;
			shift_q <= 8'h00;
			stat_q <= RST_STATUS;
			ctrl_q <= RST_CTRL;
			ev_q <= '0;
			mask_q <= '0;
			half_q <= '0;
			sclo_q <= 1'b1;
			sdao_q <= 1'b1;
			mid_q <= 1'b0;
			addr_next_q <= 1'b0;
			st_q <= SRG_IDLE;
			pins_q <= 3'h7;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			adr_q <= adr_d;
			reload_q <= reload_d;
			shift_q <= shift_d;
			stat_q <= stat_d;
			ctrl_q <= ctrl_d;
			ev_q <= ev_d;
			mask_q <= mask_d;
			half_q <= half_d;
			sclo_q <= sclo_d;
			sdao_q <= sdao_d;
			mid_q <= mid_d;
			addr_next_q <= addr_next_d;
			st_q <= st_d;
			pins_q <= pins;
		end
	end

	assign hrdata = rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// open drain in two-wire mode: enable only while pulling low
	assign scl_out = ctrl_q[CT_TWO_WIRE] ? 1'b0 : sclo_q;
	assign scl_oe_out = ctrl_q[CT_ENABLE] && ctrl_q[CT_MASTER]
		&& (ctrl_q[CT_TWO_WIRE] ? !sclo_q : 1'b1);
	assign sda_out = ctrl_q[CT_TWO_WIRE] ? 1'b0 : sdao_q;
	// a two-wire slave has no data sequencer here, so it never pulls data low
	assign sda_oe_out = ctrl_q[CT_ENABLE]
		&& (ctrl_q[CT_TWO_WIRE] ? ctrl_q[CT_MASTER] && !sdao_q : 1'b1);
	assign smbus_levels_out = ctrl_q[CT_TWO_WIRE] && stat_q[ST_EDGE];
	assign irq_out = |(ev_q & mask_q);

	AST_START_STARTS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		load |=> st_q == SRG_RUN) else $error("buffer write did not start");
	AST_STOPS_HOLDS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_q == SRG_IDLE && !load |=> $stable(sclo_q)) else $error("clock moved while idle");
	AST_TWO_ROLLS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		st_q == SRG_RUN && roll && ctrl_q[CT_ENABLE] |=> sclo_q != $past(sclo_q))
		else $error("rollover did not toggle clock");
	AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		adr_q > OFF_IRQ_MASK |-> hrdata == 32'h0000_0000) else $error("unmapped read nonzero");
	AST_DISABLE_CLEARS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!ctrl_q[CT_ENABLE] |=> !stat_q[ST_START] && !stat_q[ST_STOP])
		else $error("start or stop kept while disabled");
	AST_START_SEEN: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		start_ev && ctrl_q[CT_ENABLE] |=> stat_q[ST_START] && !stat_q[ST_STOP])
		else $error("start not flagged");
	AST_STOP_SEEN: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		stop_ev && ctrl_q[CT_ENABLE] |=> stat_q[ST_STOP] && !stat_q[ST_START])
		else $error("stop not flagged");
	AST_FULL_ON_WRITE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		buf_wr |=> stat_q[ST_FULL]) else $error("full not set on write");
	AST_SMBUS_LEVEL: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		wr_q && adr_q == OFF_STATUS && ctrl_q[CT_TWO_WIRE]
		|=> smbus_levels_out == $past(hwdata[ST_EDGE]))
		else $error("thresholds wrong");
	AST_REFRESH_CLEAR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		wr_q && adr_q == OFF_RELOAD && !byte_done |=> !stat_q[ST_ADDR_REFRESH])
		else $error("address refresh not cleared");
endmodule

// >>> inc/srg_pkg.sv
/*
 * srg_pkg: shared constants for the serial port rate generator and status block.
 * assumes: included before every design file that names srg_pkg.
 */
package srg_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_RELOAD = 8'h00;
	localparam logic [7:0] OFF_BUFFER = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	// status field positions
	localparam int ST_SAMPLE = 7;
	localparam int ST_EDGE = 6;
	localparam int ST_DATA = 5;
	localparam int ST_STOP = 4;
	localparam int ST_START = 3;
	localparam int ST_RW = 2;
	localparam int ST_ADDR_REFRESH = 1;
	localparam int ST_FULL = 0;
	// control field positions
	localparam int CT_ENABLE = 0;
	localparam int CT_MASTER = 1;
	localparam int CT_TWO_WIRE = 2;
	// interrupt event positions
	localparam int EV_DONE = 0;
	localparam int EV_START = 1;
	localparam int EV_STOP = 2;
	localparam int EV_FULL = 3;
	localparam int EV_REFRESH = 4;
	localparam int EV_WIDTH = 5;
	// reset values
	localparam logic [7:0] RST_RELOAD = 8'h4F;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [2:0] RST_CTRL = 3'h0;
	// rate counter steps at half the core clock
	localparam logic [0:0] RATE_PRESCALE_LAST = 1'h1;
	// reload values that a two-wire rate cannot use
	localparam logic [7:0] RELOAD_MIN_TWI = 8'h03;
	// bits of a byte transfer, two half periods each
	localparam logic [4:0] HALF_PERIODS = 5'h10;
	typedef enum logic [1:0] {SRG_IDLE, SRG_RUN} srg_state_t;
endpackage

// >>> verilog/srg_sync.sv
/*
 * srg_sync: three flop synchroniser with agreement filter for pin inputs.
 * assumes: input is asynchronous to ref_clk_in; output lags by four edges.
 */
`timescale 1ns/1ps
module srg_sync #(
	parameter int WIDTH = 3
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
	// accept a change only once the second and third stage agree
	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end
	// first stage feeds only the second
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			lvl_q <= '1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end
	assign level_out = lvl_q;
endmodule

// >>> verilog/srg_counter.sv
/*
 * srg_counter: down counter that reloads at zero and marks each rollover.
 * assumes: run_in and reload_in come from the same clock domain.
 */
`timescale 1ns/1ps
module srg_counter #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic run_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] reload_in,
	output logic roll_out,
	output logic [WIDTH-1:0] count_out
);
	import srg_pkg::*;
	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic [0:0] pre_q, pre_d;
	logic roll;
	// step at half the core clock; reload+1 steps per rollover
	always_comb begin
		cnt_d = cnt_q;
		pre_d = pre_q;
		roll = 1'b0;
		if (load_in) begin
			cnt_d = reload_in;
			pre_d = 1'h0;
		end else if (run_in) begin
			pre_d = pre_q + 1'h1;
			if (pre_q == RATE_PRESCALE_LAST) begin
				if (cnt_q == '0) begin
					roll = 1'b1;
					cnt_d = reload_in;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cnt_q <= '0;
			pre_q <= 1'h0;
		end else begin
			cnt_q <= cnt_d;
			pre_q <= pre_d;
		end
	end
	assign roll_out = roll;
	assign count_out = cnt_q;
	// a rollover always hands back the reload value at the next edge
	AST_ROLL_RELOAD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		roll && !load_in |=> cnt_q == $past(reload_in)) else $error("no reload on rollover");
endmodule

// >>> test/srg_peer.sv
/*
 * srg_peer: bus peer on the far side of the port pins.
 * assumes: the bench wires sda and scl as wired-and with a pull-up, sdi directly;
 * tasks are called just after a rising edge of the block clock;
 * every change lands between rising edges.
 */
`timescale 1ns/1ps
module srg_peer (
	output logic sda_drv_out,
	output logic scl_drv_out,
	output logic sdi_out
);
	// released lines float to the pull-up level, so idle is one
	initial begin
		sda_drv_out = 1'h1;
		scl_drv_out = 1'h1;
		sdi_out = 1'h0;
	end

	// spi input keeps changing so a stale sample never looks right
	always #160 sdi_out = ~sdi_out;

	// data falls while the clock is high, then the clock goes low; half link period apart
	task automatic start_cond();
		#150 sda_drv_out = 1'h0;
		#160 scl_drv_out = 1'h0;
	endtask

	// data pulled low first, then clock released, then data rises while the clock stays high
	task automatic stop_cond();
		#10 sda_drv_out = 1'h0;
		#140 scl_drv_out = 1'h1;
		#160 sda_drv_out = 1'h1;
	endtask
endmodule

// >>> test/tb_top.sv
/*
 * tb_top: register level bench for the rate generator and status block.
 * assumes: zero wait state slave; bus peer model in srg_peer.
 */
`timescale 1ns/1ps
module tb_top;
	import srg_pkg::*;
	logic ref_clk_in, sys_rst_in, hsel, hwrite, ten_bit_addr_in;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, scl_out, scl_oe_out, sda_out, sda_oe_out, smbus_levels_out, irq_out;
	logic peer_sda, peer_scl, peer_sdi;
	logic [7:0] rl [2] = '{8'h03, 8'h13};
	int errors, cmp_count, tg, gp;
	// open-drain lines with pull-ups: any party pulling low wins
	wire sda_line = (sda_oe_out ? sda_out : 1'h1) & peer_sda;
	wire scl_line = (scl_oe_out ? scl_out : 1'h1) & peer_scl;

	srg_top dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sda_in(sda_line), .scl_in(scl_line), .sdi_in(peer_sdi),
		.ten_bit_addr_in(ten_bit_addr_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
		.sda_out(sda_out), .sda_oe_out(sda_oe_out), .smbus_levels_out(smbus_levels_out),
		.irq_out(irq_out));
	srg_peer peer_u (.sda_drv_out(peer_sda), .scl_drv_out(peer_scl), .sdi_out(peer_sdi));

	initial begin
		ref_clk_in = 1'h0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end

	task automatic end_of_test();
		$display("checks %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one single transfer; called just after a rising edge, ends on the edge closing data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		int n;
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		// address phase stands until hready is seen high at a rising edge
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		// read data is taken at the edge that sees hready high again
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (hreadyout !== 1'h1 && n < 100);
		r = hrdata;
		if (hreadyout !== 1'h1) begin
			errors++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'h1, a, d, dummy);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp,
		input string nm);
		bus(1'h0, a, 32'h0, rd);
		check(nm, rd & msk, exp);
	endtask

	// count clock pin changes and the spacing of the last two over a fixed window
	task automatic watch_scl(output int toggles, output int gap);
		int c;
		logic last;
		toggles = 0;
		gap = 0;
		c = 0;
		last = scl_out;
		repeat (900) begin
			@(negedge ref_clk_in);
			c++;
			if (scl_out !== last) begin
				toggles++;
				gap = c;
				c = 0;
				last = scl_out;
			end
		end
		@(posedge ref_clk_in);
	endtask

	// level checks land between edges so no update of the same step is missed
	task automatic pin_chk(input string nm, input logic exp);
		@(negedge ref_clk_in);
		check(nm, {31'h0, irq_out}, {31'h0, exp});
		@(posedge ref_clk_in);
	endtask

	initial begin
		errors = 0;
		cmp_count = 0;
		sys_rst_in = 1'h1;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		ten_bit_addr_in = 1'h0;
		repeat (3) @(posedge ref_clk_in);
		sys_rst_in <= 1'h0;
		@(posedge ref_clk_in);
		rdc(OFF_RELOAD, 32'hFFFFFFFF, 32'h4F, "reload_reset");
		rdc(OFF_STATUS, 32'hFFFFFFFF, 32'h0, "status_reset");
		wr(8'h18, 32'hFFFFFFFF);
		rdc(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
		wr(OFF_IRQ_MASK, 32'h0);
		wr(OFF_CTRL, 32'h3);
		// spi master runs; reloads of three and up only, as a two-wire rate demands too
		for (int i = 0; i < 2; i++) begin
			wr(OFF_RELOAD, {24'hFFFFFF, rl[i]});
			rdc(OFF_RELOAD, 32'hFFFFFFFF, {24'h0, rl[i]}, "reload_bits");
			wr(OFF_BUFFER, 32'hA5);
			rdc(OFF_STATUS, 32'h1, 32'h1, "full_on_write");
			check("scl_drive", {31'h0, scl_oe_out}, 32'h1);
			watch_scl(tg, gp);
			check("scl_toggles", tg, 32'd16);
			check("half_period", gp, 2 * (32'(rl[i]) + 1));
			if (i == 0) begin
				pin_chk("irq_masked", 1'h0);
				rdc(OFF_IRQ_STAT, 32'h1, 32'h1, "done_event");
				wr(OFF_IRQ_MASK, 32'h1);
				pin_chk("irq_raised", 1'h1);
				wr(OFF_IRQ_STAT, 32'h1);
				pin_chk("irq_cleared", 1'h0);
			end
		end
		// every bit is sampled at the same phase of the toggling input: all zero or all one
		bus(1'h0, OFF_BUFFER, 32'h0, rd);
		check("buffer_read", {31'h0, rd[7:0] == 8'h00 || rd[7:0] == 8'hFF}, 32'h1);
		rdc(OFF_STATUS, 32'h1, 32'h0, "full_cleared");
		// two-wire slave: thresholds bit, then start and stop seen from the peer
		wr(OFF_CTRL, 32'h5);
		wr(OFF_STATUS, 32'h40);
		@(negedge ref_clk_in);
		check("smbus_levels", {31'h0, smbus_levels_out}, 32'h1);
		@(posedge ref_clk_in);
		peer_u.start_cond();
		repeat (8) @(posedge ref_clk_in);
		rdc(OFF_STATUS, 32'h18, 32'h08, "start_seen");
		peer_u.stop_cond();
		repeat (8) @(posedge ref_clk_in);
		rdc(OFF_STATUS, 32'h18, 32'h10, "stop_seen");
		rdc(OFF_IRQ_STAT, 32'h6, 32'h6, "cond_events");
		// two-wire master after a start: the first byte is an address, the next is data
		wr(OFF_CTRL, 32'h7);
		peer_u.start_cond();
		repeat (8) @(posedge ref_clk_in);
		for (int j = 0; j < 2; j++) begin
			wr(OFF_BUFFER, 32'h3C);
			repeat (700) @(posedge ref_clk_in);
			rdc(OFF_STATUS, 32'h20, {26'h0, j[0], 5'h0}, "data_address");
		end
		peer_u.stop_cond();
		repeat (8) @(posedge ref_clk_in);
		// disabling the port wipes both bus condition bits
		wr(OFF_CTRL, 32'h0);
		rdc(OFF_STATUS, 32'h18, 32'h0, "cond_cleared");
		end_of_test();
	end
endmodule
